// ===== hw/agc_loop_ctrl.v
/*
 * Receive gain-control loop: configuration register, amplitude
 * averaging, dead-zone decision with hysteresis, settling wait,
 * gain hold policy and on-off keyed slicing.
 * Assumes all inputs synchronous to mclk and a register master that
 * never issues read and write strobes together.
 */
`timescale 1ns/1ps
`include "agc_loop_defines.vh"

module agc_loop_ctrl (
    input  wire        mclk,
    input  wire        rst,
    input  wire [15:0] reg_addr,
    input  wire [7:0]  reg_wdata,
    input  wire        reg_wr,
    input  wire        reg_rd,
    output reg  [7:0]  reg_rdata,
    input  wire        samp_valid,
    input  wire [7:0]  samp_mag,
    input  wire        sync_found,
    input  wire        rx_restart,
    input  wire        ook_mode,
    output wire [2:0]  analog_gain,
    output wire [2:0]  digital_gain,
    output wire        gain_step,
    output wire        ook_bit,
    output wire [7:0]  amp_avg
);

    // ============================================================
    // Register state
    reg  [7:0] agc_control_0_q;
    reg  [2:0] ana_gain_q;
    reg  [2:0] ana_gain_d;
    reg  [2:0] dig_gain_q;
    reg  [2:0] dig_gain_d;
    reg        sync_seen_q;
    reg        step_q;
    reg        step_d;
    reg        last_up_q;
    reg        last_up_d;
    reg        last_dn_q;
    reg        last_dn_d;
    reg        ook_bit_q;

    wire [1:0] gain_hysteresis_level;
    wire [1:0] wait_sel;
    wire [1:0] gain_hold_select;
    wire [1:0] filt_sel;

    wire       avg_valid;
    wire [7:0] avg_mag;
    wire       settling;

    wire       wr_ctrl;
    wire       wr_gain;
    wire [2:0] hit;
    wire       filt_chg;

    assign gain_hysteresis_level =
        agc_control_0_q[`HYST_MSB:`HYST_LSB];
    assign wait_sel         = agc_control_0_q[`WAIT_MSB:`WAIT_LSB];
    assign gain_hold_select = agc_control_0_q[`HOLD_MSB:`HOLD_LSB];
    assign filt_sel         = agc_control_0_q[`FILT_MSB:`FILT_LSB];

    // One-hot register select: control, gain, status
    function [2:0] reg_sel;
        input [15:0] addr;
        begin
            reg_sel = {addr == `AGC_STAT_ADDR,
                       addr == `AGC_GAIN_ADDR,
                       addr == `AGC_CTRL0_ADDR};
        end
    endfunction

    assign hit     = reg_sel(reg_addr);
    assign wr_ctrl = reg_wr && hit[0];
    assign wr_gain = reg_wr && hit[1];

    // New block length restarts the average in progress
    assign filt_chg = wr_ctrl &&
        (reg_wdata[`FILT_MSB:`FILT_LSB] != filt_sel);

    // ============================================================
    // Configuration register
    always @(posedge mclk) begin
        if (rst) begin
            agc_control_0_q <= `AGC_CTRL0_RST; // see RULE1 see RULE3
        end else if (wr_ctrl) begin
            agc_control_0_q <= reg_wdata;
        end
    end

    // ============================================================
    // Sync word latch, set wins over restart
    always @(posedge mclk) begin
        if (rst) begin
            sync_seen_q <= 1'b0;
        end else begin
            sync_seen_q <= sync_found | (sync_seen_q & ~rx_restart);
        end
    end

    // ============================================================
    // Amplitude averaging and settling wait
    agc_amp_avg u_avg (
        .mclk       (mclk),
        .rst        (rst),
        .len_sel    (filt_sel),
        .clr        (step_q | settling | filt_chg),
        .samp_valid (samp_valid),
        .samp_mag   (samp_mag),
        .avg_valid  (avg_valid),
        .avg_mag    (avg_mag)
    ); // see RULE7

    agc_settle_wait u_wait (
        .mclk       (mclk),
        .rst        (rst),
        .wait_sel   (wait_sel),
        .start      (step_q),
        .samp_valid (samp_valid),
        .busy       (settling)
    ); // see RULE2

    // ============================================================
    // Dead zone edges for a hysteresis level
    function [8:0] dz_up;
        input [1:0] lvl;
        begin
            case (lvl)
                2'h0:    dz_up = `DZ_UP_L0;
                2'h1:    dz_up = `DZ_UP_L1;
                2'h2:    dz_up = `DZ_UP_L2;
                default: dz_up = `DZ_UP_L3;
            endcase
        end
    endfunction

    function [8:0] dz_dn;
        input [1:0] lvl;
        begin
            case (lvl)
                2'h0:    dz_dn = `DZ_DN_L0;
                2'h1:    dz_dn = `DZ_DN_L1;
                2'h2:    dz_dn = `DZ_DN_L2;
                default: dz_dn = `DZ_DN_L3;
            endcase
        end
    endfunction

    // Extra margin to reverse direction; none at level zero
    function [8:0] rev_margin;
        input [1:0] lvl;
        begin
            rev_margin = `HYST_STEP * {7'h00, lvl};
        end
    endfunction

    // ============================================================
    // Deviation and decision
    wire [8:0] up_edge;
    wire [8:0] dn_edge;
    wire [8:0] over;
    wire [8:0] under;
    wire       too_high;
    wire       too_low;
    wire       above;

    assign above   = (avg_mag > `MAGN_TARGET);
    assign over    = {1'b0, avg_mag} - {1'b0, `MAGN_TARGET};
    assign under   = {1'b0, `MAGN_TARGET} - {1'b0, avg_mag};

    // Symmetric zone at level zero, widening and skewed above it
    assign up_edge = dz_up(gain_hysteresis_level) +
                     (last_up_q ? rev_margin(gain_hysteresis_level)
                                : 9'h000); // see RULE1
    assign dn_edge = dz_dn(gain_hysteresis_level) +
                     (last_dn_q ? rev_margin(gain_hysteresis_level)
                                : 9'h000); // see RULE1

    assign too_high = above && (over > up_edge);
    assign too_low  = !above && (under > dn_edge);

    // ============================================================
    // Hold policy
    reg ana_free;
    reg dig_free;

    always @* begin
        case (gain_hold_select)
            `HOLD_NONE: begin
                ana_free = 1'b1; // see RULE3
                dig_free = 1'b1;
            end
            `HOLD_SYNC: begin
                ana_free = ~(sync_seen_q | sync_found); // see RULE4
                dig_free = ~(sync_seen_q | sync_found);
            end
            `HOLD_ANALOG: begin
                ana_free = 1'b0; // see RULE5
                dig_free = 1'b1;
            end
            default: begin
                ana_free = 1'b0; // see RULE6
                dig_free = 1'b0;
            end
        endcase
    end

    // ============================================================
    // Gain update: analog falls first, digital rises first
    wire decide;

    assign decide = avg_valid && !settling && !step_q; // see RULE2

    always @* begin
        ana_gain_d = ana_gain_q;
        dig_gain_d = dig_gain_q;
        step_d     = 1'b0;
        last_up_d  = last_up_q;
        last_dn_d  = last_dn_q;
        if (wr_gain && gain_hold_select == `HOLD_BOTH) begin
            ana_gain_d = reg_wdata[`ANA_MSB:`ANA_LSB]; // see RULE6
            dig_gain_d = reg_wdata[`DIG_MSB:`DIG_LSB];
        end else if (decide && too_high) begin
            if (ana_free && ana_gain_q != 3'h0) begin
                ana_gain_d = ana_gain_q - 3'h1;
                step_d     = 1'b1;
            end else if (dig_free && dig_gain_q != 3'h0) begin
                dig_gain_d = dig_gain_q - 3'h1;
                step_d     = 1'b1;
            end
            if (step_d) begin
                last_dn_d = 1'b1;
                last_up_d = 1'b0;
            end
        end else if (decide && too_low) begin
            if (dig_free && dig_gain_q != `GAIN_MAX) begin
                dig_gain_d = dig_gain_q + 3'h1;
                step_d     = 1'b1;
            end else if (ana_free && ana_gain_q != `GAIN_MAX) begin
                ana_gain_d = ana_gain_q + 3'h1;
                step_d     = 1'b1;
            end
            if (step_d) begin
                last_up_d = 1'b1;
                last_dn_d = 1'b0;
            end
        end
    end

    always @(posedge mclk) begin
        if (rst) begin
            ana_gain_q <= `ANA_GAIN_RST;
            dig_gain_q <= `DIG_GAIN_RST;
            step_q     <= 1'b0;
            last_up_q  <= 1'b0;
            last_dn_q  <= 1'b0;
        end else begin
            ana_gain_q <= ana_gain_d;
            dig_gain_q <= dig_gain_d;
            step_q     <= step_d;
            last_up_q  <= last_up_d;
            last_dn_q  <= last_dn_d;
        end
    end

    // ============================================================
    // On-off keyed slicer against the averaged amplitude
    always @(posedge mclk) begin
        if (rst) begin
            ook_bit_q <= 1'b0;
        end else if (samp_valid && ook_mode) begin
            ook_bit_q <= (samp_mag >= avg_mag); // see RULE8
        end
    end

    // ============================================================
    // Register read, data one cycle after the strobe
    always @(posedge mclk) begin
        if (rst) begin
            reg_rdata <= 8'h00;
        end else if (reg_rd) begin
            case (hit)
                3'h1:    reg_rdata <= agc_control_0_q;
                3'h2:    reg_rdata <= {1'b0, ana_gain_q,
                                       1'b0, dig_gain_q};
                3'h4:    reg_rdata <= {5'h00, ook_bit_q,
                                       sync_seen_q, settling};
                default:         reg_rdata <= 8'h00;
            endcase
        end else begin
            reg_rdata <= 8'h00;
        end
    end

    assign analog_gain  = ana_gain_q;
    assign digital_gain = dig_gain_q;
    assign gain_step    = step_q;
    assign ook_bit      = ook_bit_q;
    assign amp_avg      = avg_mag;

endmodule // agc_loop_ctrl

// ===== hw/agc_loop_defines.vh
/*
 * Constants for the receive gain-control loop: register addresses,
 * field positions, reset values, dead zones and gain limits.
 * Assumes inclusion by bare name from the design files of this block.
 */
// Overview of operation
// RULE1: Hysteresis level picks none, low, medium or large dead zone; resets medium. Level zero still keeps a dead zone of 2 either side of the target.
// RULE2: After a gain step, wait 8, 16, 24 or 32 samples before accumulating.
// RULE3: Hold select zero adjusts gain freely; this is the reset value.
// RULE4: Hold select one stops gain changes once a sync word is found.
// RULE5: Hold select two fixes analog gain, digital gain still adjusts.
// RULE6: Hold select three fixes both gains, allowing manual gain override.
// RULE7: Amplitude averages over 8, 16, 32 or 64 samples; resets to 16.
// RULE8: On-off keyed decisions use a boundary from the same averaging length.
`ifndef AGC_LOOP_DEFINES_VH
`define AGC_LOOP_DEFINES_VH

// ============================================================
// Register map
`define AGC_CTRL0_ADDR  16'hDF19
`define AGC_GAIN_ADDR   16'hDF3E
`define AGC_STAT_ADDR   16'hDF3F
`define AGC_CTRL0_RST   8'h91

// ============================================================
// Fields of agc_control_0
`define HYST_MSB        7
`define HYST_LSB        6
`define WAIT_MSB        5
`define WAIT_LSB        4
`define HOLD_MSB        3
`define HOLD_LSB        2
`define FILT_MSB        1
`define FILT_LSB        0

// ============================================================
// Gain hold selections
`define HOLD_NONE       2'h0
`define HOLD_SYNC       2'h1
`define HOLD_ANALOG     2'h2
`define HOLD_BOTH       2'h3

// ============================================================
// Gain register fields and limits
`define ANA_MSB         6
`define ANA_LSB         4
`define DIG_MSB         2
`define DIG_LSB         0
`define GAIN_MAX        3'h7
`define ANA_GAIN_RST    3'h7
`define DIG_GAIN_RST    3'h0

// ============================================================
// Magnitude target and dead zones, upper and lower edges
`define MAGN_TARGET     8'h40
`define DZ_UP_L0        9'h002
`define DZ_DN_L0        9'h002
`define DZ_UP_L1        9'h004
`define DZ_DN_L1        9'h002
`define DZ_UP_L2        9'h008
`define DZ_DN_L2        9'h004
`define DZ_UP_L3        9'h010
`define DZ_DN_L3        9'h006
`define HYST_STEP       9'h002

// ============================================================
// Sample counts
`define WAIT_UNIT       6'h08
`define FILT_BASE       7'h08

`endif

// ===== hw/agc_settle_wait.v
/*
 * Settling counter: after a gain step it counts channel-filter
 * samples and holds busy until the programmed number has passed.
 * Assumes one sample valid pulse per channel-filter sample.
 */
`timescale 1ns/1ps
`include "agc_loop_defines.vh"

module agc_settle_wait (
    input  wire       mclk,
    input  wire       rst,
    input  wire [1:0] wait_sel,
    input  wire       start,
    input  wire       samp_valid,
    output wire       busy
);

    reg  [5:0] cnt_q;
    reg  [5:0] cnt_d;
    wire [5:0] load_val;

    // 8, 16, 24 or 32 samples
    assign load_val = ({4'h0, wait_sel} + 6'h01) * `WAIT_UNIT; // see RULE2

    always @* begin
        cnt_d = cnt_q;
        if (start) begin
            cnt_d = load_val; // see RULE2
        end else if (samp_valid && cnt_q != 6'h00) begin
            cnt_d = cnt_q - 6'h01;
        end
    end

    always @(posedge mclk) begin
        if (rst) begin
            cnt_q <= 6'h00;
        end else begin
            cnt_q <= cnt_d;
        end
    end

    assign busy = (cnt_q != 6'h00);

endmodule // agc_settle_wait

// ===== hw/agc_amp_avg.v
/*
 * Block averager of channel-filter amplitude over 8, 16, 32 or 64
 * samples; emits one averaged magnitude per block.
 * Assumes samples arrive as one-cycle valid pulses.
 */
`timescale 1ns/1ps
`include "agc_loop_defines.vh"

module agc_amp_avg (
    input  wire       mclk,
    input  wire       rst,
    input  wire [1:0] len_sel,
    input  wire       clr,
    input  wire       samp_valid,
    input  wire [7:0] samp_mag,
    output reg        avg_valid,
    output reg  [7:0] avg_mag
);

    reg  [5:0]  cnt_q;
    reg  [13:0] acc_q;
    wire [13:0] sum;
    wire [6:0]  len;

    // Block length for a selection code
    function [6:0] len_of;
        input [1:0] sel;
        begin
            len_of = `FILT_BASE << sel;
        end
    endfunction

    // Scale a block sum down by its length
    function [7:0] scale;
        input [13:0] s;
        input [1:0]  sel;
        begin
            case (sel)
                2'h0:    scale = s[10:3];
                2'h1:    scale = s[11:4];
                2'h2:    scale = s[12:5];
                default: scale = s[13:6];
            endcase
        end
    endfunction

    assign len = len_of(len_sel); // see RULE7
    assign sum = acc_q + {6'h00, samp_mag};

    always @(posedge mclk) begin
        if (rst) begin
            cnt_q     <= 6'h00;
            acc_q     <= 14'h0000;
            avg_valid <= 1'b0;
            avg_mag   <= 8'h00;
        end else begin
            avg_valid <= 1'b0;
            if (clr) begin
                cnt_q <= 6'h00;
                acc_q <= 14'h0000;
            end else if (samp_valid) begin
                if ({1'b0, cnt_q} == len - 7'h01) begin
                    cnt_q     <= 6'h00;
                    acc_q     <= 14'h0000;
                    avg_valid <= 1'b1;
                    avg_mag   <= scale(sum, len_sel); // see RULE7
                end else begin
                    cnt_q <= cnt_q + 6'h01;
                    acc_q <= sum;
                end
            end
        end
    end

endmodule // agc_amp_avg

// ===== testbench/agc_loop_ctrl_checker.sv
/* Checker for agc_loop_ctrl: read data, gain step pacing, hold policy
   and slicer output. Assumes only the ports of agc_loop_ctrl. */
`timescale 1ns/1ps
`include "agc_loop_defines.vh"
module agc_loop_ctrl_checker (
    input wire logic        mclk,
    input wire logic        rst,
    input wire logic [15:0] reg_addr,
    input wire logic [7:0]  reg_wdata,
    input wire logic        reg_wr,
    input wire logic        reg_rd,
    input wire logic [7:0]  reg_rdata,
    input wire logic        samp_valid,
    input wire logic [7:0]  samp_mag,
    input wire logic        sync_found,
    input wire logic        rx_restart,
    input wire logic        ook_mode,
    input wire logic [2:0]  analog_gain,
    input wire logic [2:0]  digital_gain,
    input wire logic        gain_step,
    input wire logic        ook_bit,
    input wire logic [7:0]  amp_avg
);
    logic [7:0] ctrl_q;
    logic [1:0] hold_q;
    logic       man_wr_q;
    wire        mapped = reg_addr == `AGC_CTRL0_ADDR ||
                         reg_addr == `AGC_GAIN_ADDR || reg_addr == `AGC_STAT_ADDR;
    // ====================================================
    // Shadow of the control register
    always @(posedge mclk) begin
        if (rst) begin
            ctrl_q   <= 8'h91;
            hold_q   <= 2'h0;
            man_wr_q <= 1'b0;
        end else begin
            if (reg_wr && reg_addr == `AGC_CTRL0_ADDR) begin
                ctrl_q <= reg_wdata;
            end
            hold_q   <= ctrl_q[3:2];
            man_wr_q <= reg_wr && reg_addr == `AGC_GAIN_ADDR && ctrl_q[3:2] == 2'h3;
        end
    end
    // ====================================================
    // Properties
    default clocking @(posedge mclk); endclocking
    default disable iff (rst);
    sequence s_quiet; !gain_step [*8]; endsequence
    property p_rd_idle; !reg_rd |=> reg_rdata == 8'h00; endproperty
    property p_rd_ctrl; reg_rd && reg_addr == `AGC_CTRL0_ADDR |=> reg_rdata == ctrl_q;
    endproperty
    property p_rd_unmapped; reg_rd && !mapped |=> reg_rdata == 8'h00; endproperty
    property p_step_gap; gain_step |=> s_quiet; endproperty
    property p_step_cause; gain_step |-> $past(samp_valid, 2); endproperty
    property p_step_size; gain_step |->
        ($stable(digital_gain) && (analog_gain - $past(analog_gain) == 3'h1 ||
                                    $past(analog_gain) - analog_gain == 3'h1)) ||
        ($stable(analog_gain) && (digital_gain - $past(digital_gain) == 3'h1 ||
                                   $past(digital_gain) - digital_gain == 3'h1));
    endproperty
    property p_change_cause; !$past(rst) && ($changed(analog_gain) ||
        $changed(digital_gain)) |-> gain_step || man_wr_q; endproperty
    property p_hold_both; hold_q == `HOLD_BOTH && ctrl_q[3:2] == `HOLD_BOTH |-> !gain_step;
    endproperty
    property p_hold_analog; !$past(rst) && hold_q == `HOLD_ANALOG &&
        ctrl_q[3:2] == `HOLD_ANALOG |-> $stable(analog_gain); endproperty
    property p_ook; samp_valid && ook_mode |=> $changed(amp_avg) ||
        ook_bit == ($past(samp_mag) >= $past(amp_avg)); endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("read data not idle");
    a_rd_ctrl: assert property (p_rd_ctrl) else $error("control read wrong");
    a_rd_unmapped: assert property (p_rd_unmapped) else $error("unmapped read");
    a_step_gap: assert property (p_step_gap) else $error("step too soon");
    a_step_cause: assert property (p_step_cause) else $error("step w/o sample");
    a_step_size: assert property (p_step_size) else $error("bad step size");
    a_change_cause: assert property (p_change_cause) else $error("gain moved");
    a_hold_both: assert property (p_hold_both) else $error("step in hold");
    a_hold_analog: assert property (p_hold_analog) else $error("analog moved");
    a_ook: assert property (p_ook) else $error("slicer output wrong");
endmodule // agc_loop_ctrl_checker

bind agc_loop_ctrl agc_loop_ctrl_checker u_chk (.mclk(mclk), .rst(rst),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .samp_valid(samp_valid), .samp_mag(samp_mag),
    .sync_found(sync_found), .rx_restart(rx_restart), .ook_mode(ook_mode),
    .analog_gain(analog_gain), .digital_gain(digital_gain),
    .gain_step(gain_step), .ook_bit(ook_bit), .amp_avg(amp_avg));

// ===== testbench/agc_loop_ctrl_bench.sv
/* Bench for agc_loop_ctrl: drives registers and samples, checks read
   data, gain steps and slicer output from expectation queues, and averages directly.
   Assumes the checker is bound in from its own file. */
`timescale 1ns/1ps
`include "agc_loop_defines.vh"
module agc_loop_ctrl_bench;
    logic        mclk = 1'b0, rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
    logic        samp_valid = 1'b0, sync_found = 1'b0, rx_restart = 1'b0;
    logic        ook_mode = 1'b0, gain_step, ook_bit, rd_seen = 1'b0, ook_seen = 1'b0;
    logic [15:0] reg_addr = 16'h0000;
    logic [7:0]  reg_wdata = 8'h00, samp_mag = 8'h00, reg_rdata, amp_avg, r, bnd;
    logic [2:0]  analog_gain, digital_gain, ana = 3'h7, dig = 3'h0;
    logic [7:0]  rd_q[$];
    logic [5:0]  gain_q[$];
    logic        ook_q[$];
    logic [7:0]  edge_tab [4] = '{8'h02, 8'h04, 8'h08, 8'h10};
    int          errors = 0, tests_run = 0, steps = 0, exp_steps = 0;
    localparam logic [15:0] CTRL = `AGC_CTRL0_ADDR;
    localparam logic [15:0] GAIN = `AGC_GAIN_ADDR;

    agc_loop_ctrl DUT (.mclk(mclk), .rst(rst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .samp_valid(samp_valid), .samp_mag(samp_mag),
        .sync_found(sync_found), .rx_restart(rx_restart), .ook_mode(ook_mode),
        .analog_gain(analog_gain), .digital_gain(digital_gain),
        .gain_step(gain_step), .ook_bit(ook_bit), .amp_avg(amp_avg));

    always #50 mclk = ~mclk;
    // ====================================================
    // Compare tasks and bus tasks
    task check_byte(input string n, input logic [7:0] e, input logic [7:0] g);
        tests_run++;
        if (g !== e) begin
            errors++;
            $display("Error %s expected %h seen %h", n, e, g);
        end
    endtask
    task check_gain(input logic [5:0] e, input logic [5:0] g);
        tests_run++;
        if (g !== e) begin
            errors++;
            $display("Error gain expected %h seen %h", e, g);
        end
    endtask
    task wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge mclk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge mclk);
        reg_wr <= 1'b0;
    endtask
    task rd(input logic [15:0] a, input logic [7:0] e);
        rd_q.push_back(e);
        @(posedge mclk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge mclk);
        reg_rd <= 1'b0;
    endtask
    task samp(input logic [7:0] m);
        @(posedge mclk);
        if (ook_mode) ook_q.push_back(m >= bnd);
        samp_valid <= 1'b1;
        samp_mag <= m;
        @(posedge mclk);
        samp_valid <= 1'b0;
    endtask
    task blk(input logic [7:0] m, input int n);
        repeat (n) samp(m);
    endtask
    task step_to(input logic [2:0] a, input logic [2:0] d);
        ana = a;
        dig = d;
        gain_q.push_back({a, d});
        exp_steps++;
    endtask
    task check_steps;
        repeat (4) @(posedge mclk);
        check_byte("steps", exp_steps[7:0], steps[7:0]);
    endtask
    task give_verdict;
        $display("Comparisons %0d mismatches %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    // ====================================================
    // Output monitor
    always @(posedge mclk) begin
        if (rd_seen) check_byte("reg_rdata", rd_q.pop_front(), reg_rdata);
        if (ook_seen) check_byte("ook_bit", {7'h00, ook_q.pop_front()}, {7'h00, ook_bit});
        if (gain_step === 1'b1 && gain_q.size() > 0) begin
            check_gain(gain_q.pop_front(), {analog_gain, digital_gain});
        end
        if (gain_step === 1'b1) steps++;
        rd_seen <= reg_rd;
        ook_seen <= samp_valid & ook_mode;
    end
    initial begin
        repeat (5000) @(posedge mclk);
        errors++;
        give_verdict;
    end
    // ====================================================
    // Main sequence
    initial begin
        void'($urandom(70345));
        repeat (20) @(posedge mclk);
        rst <= 1'b0;
        rd(CTRL, {2'b10, 2'b01, 2'b00, 2'b01});
        rd(16'hDF20, 8'h00);
        wr(16'hDF20, 8'h5A);
        wr(GAIN, 8'h00);
        rd(GAIN, 8'h70);
        r = 8'($urandom);
        wr(CTRL, r);
        rd(CTRL, r);
        wr(CTRL, 8'h00);
        step_to(3'h6, 3'h0);
        blk(8'hFF, 8);
        check_steps;
        blk(8'h40, 8);
        for (int l = 0; l < 4; l++) begin
            wr(CTRL, {l[1:0], 6'h00});
            blk(8'h40 + edge_tab[l], 8);
            check_steps;
            step_to(ana - 3'h1, dig);
            blk(8'h41 + edge_tab[l], 8);
            check_steps;
            blk(8'h40, 8);
        end
        blk(8'h34, 8);
        check_steps;
        step_to(ana, dig + 3'h1);
        blk(8'h33, 8);
        for (int w = 0; w < 4; w++) begin
            repeat (4) @(posedge mclk);
            blk(8'h00, (w + 1) * 8 + 7);
            check_steps;
            wr(CTRL, {2'b00, (w < 3) ? w[1:0] + 2'b01 : 2'b11, 4'h0});
            step_to(ana, dig + 3'h1);
            samp(8'h00);
            check_steps;
        end
        wr(CTRL, 8'h04);
        blk(8'h40, 40);
        @(posedge mclk) sync_found <= 1'b1;
        @(posedge mclk) sync_found <= 1'b0;
        blk(8'h00, 8);
        check_steps;
        @(posedge mclk) rx_restart <= 1'b1;
        @(posedge mclk) rx_restart <= 1'b0;
        step_to(ana, dig + 3'h1);
        blk(8'h00, 8);
        check_steps;
        wr(CTRL, 8'h08);
        blk(8'h40, 8);
        step_to(ana, dig - 3'h1);
        blk(8'hFF, 8);
        check_steps;
        blk(8'h40, 8);
        wr(CTRL, 8'h0C);
        blk(8'hFF, 8);
        check_steps;
        r = 8'($urandom) & 8'h77;
        wr(GAIN, r);
        rd(GAIN, r);
        check_gain({r[6:4], r[2:0]}, {analog_gain, digital_gain});
        for (int f = 0; f < 4; f++) begin
            wr(CTRL, {6'h00, f[1:0]});
            blk(8'h6F + f[7:0], 4 << f);
            blk(8'h0F + f[7:0], 4 << f);
            check_steps;
            check_byte("amp_avg", 8'h3F + f[7:0], amp_avg);
        end
        bnd = 8'h42;
        wr(CTRL, 8'h0F);
        ook_mode <= 1'b1;
        samp(8'h42);
        samp(8'h41);
        for (int i = 0; i < 6; i++) begin
            r = 8'($urandom);
            samp(r);
        end
        ook_mode <= 1'b0;
        check_steps;
        give_verdict;
    end
endmodule // agc_loop_ctrl_bench
